// ==== verilog/sfd_pkg.sv ====
/*
 * Shared types and constants for the serial frame decoder.
 * Assumes a 100 MHz system clock and a serial clock driven by the host.
 */
package sfd_pkg;

    localparam int SFD_ADDR_W = 16;
    localparam int SFD_DATA_W = 8;
    localparam int SFD_FIFO_DEPTH = 16;

    // Control byte field positions
    localparam int SFD_BLK_MSB = 7;
    localparam int SFD_BLK_LSB = 3;
    localparam int SFD_DIR_BIT = 2;
    localparam int SFD_MODE_MSB = 1;
    localparam int SFD_MODE_LSB = 0;

    // Direction bit encoding
    localparam logic SFD_DIR_READ = 1'h0;
    localparam logic SFD_DIR_WRITE = 1'h1;

    // Length-mode field encodings and fixed byte counts
    localparam logic [1:0] SFD_MODE_VAR = 2'h0;
    localparam logic [1:0] SFD_MODE_FIX1 = 2'h1;
    localparam logic [1:0] SFD_MODE_FIX2 = 2'h2;
    localparam logic [1:0] SFD_MODE_FIX4 = 2'h3;
    localparam logic [2:0] SFD_LEN_FIX1 = 3'h1;
    localparam logic [2:0] SFD_LEN_FIX2 = 3'h2;
    localparam logic [2:0] SFD_LEN_FIX4 = 3'h4;

    // Block select decoding
    localparam logic [4:0] SFD_BLK_COMMON = 5'h00;
    localparam logic [4:0] SFD_BLK_S7_RX = 5'h1F;
    localparam logic [1:0] SFD_AREA_COMMON = 2'h0;
    localparam logic [1:0] SFD_AREA_REG = 2'h1;
    localparam logic [1:0] SFD_AREA_TX = 2'h2;
    localparam logic [1:0] SFD_AREA_RX = 2'h3;

    // Reset values and last bit index
    localparam logic [SFD_ADDR_W-1:0] SFD_ADDR_RST = 16'h0000;
    localparam logic [SFD_DATA_W-1:0] SFD_DATA_RST = 8'h00;
    localparam logic [2:0] SFD_BIT_RST = 3'h0;
    localparam logic [2:0] SFD_LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        SFD_PH_ADDR_HI,
        SFD_PH_ADDR_LO,
        SFD_PH_CTRL,
        SFD_PH_DATA
    } sfd_phase_t;

    typedef struct packed {
        logic [SFD_ADDR_W-1:0] addr;
        logic [4:0] block;
        logic [2:0] socket;
        logic [1:0] area;
        logic reserved;
        logic isWrite;
        logic [SFD_DATA_W-1:0] data;
    } sfd_access_t;

    localparam int SFD_ACC_W = $bits(sfd_access_t);

endpackage

// ==== verilog/sfd_frame_decode.sv ====
/*
 * Serial frame decoder: shifts frames in on the host serial clock, decodes
 * address, control byte and data phase, and hands each access to the system
 * clock side through a 16-word FIFO. Read data is returned on the data-out pin.
 * Assumes mode 0 timing: host changes bits on falling edge, samples on rising.
 */
`timescale 1ns/1ps

module sfd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Output stage is a register so the consumer sees flop-driven data
    assign push = inValid && inReady;
    assign pop = (count != '0) && (!outValid || outReady);

    // Ready follows the next count, so a full FIFO refuses at once
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            inReady <= 1'b1;
        end else begin
            inReady <= (count + (AW+1)'(push) - (AW+1)'(pop))
                < (AW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            outValid <= 1'b0;
            outData <= '0;
        end else if (pop) begin
            outValid <= 1'b1;
            outData <= mem[rdPtr];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule

module sfd_frame_decode
    import sfd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic frameSelectN,
    input wire logic mosi,
    output logic misoOut,
    output logic misoOe,
    output logic accValid,
    input wire logic accReady,
    output sfd_access_t accWord,
    input wire logic rdValid,
    input wire logic [SFD_DATA_W-1:0] rdData,
    output logic overflow,
    input wire logic clrOverflow
);

    function automatic logic [2:0] fnLen(input logic [1:0] mode);
        unique case (mode)
            SFD_MODE_FIX1: fnLen = SFD_LEN_FIX1;
            SFD_MODE_FIX2: fnLen = SFD_LEN_FIX2;
            SFD_MODE_FIX4: fnLen = SFD_LEN_FIX4;
            SFD_MODE_VAR: fnLen = 3'h0;
        endcase
    endfunction

    function automatic sfd_access_t fnPack(
        input logic [SFD_ADDR_W-1:0] a,
        input logic [4:0] blk,
        input logic dir,
        input logic [SFD_DATA_W-1:0] d
    );
        fnPack.addr = a;
        fnPack.block = blk;
        // 11111 lands on socket 7, area RX
        fnPack.socket = blk[4:2];
        fnPack.area = (blk == SFD_BLK_COMMON) ? SFD_AREA_COMMON : blk[1:0];
        fnPack.reserved = (blk != SFD_BLK_COMMON) && (blk[1:0] == 2'h0);
        fnPack.isWrite = (dir == SFD_DIR_WRITE);
        fnPack.data = d;
    endfunction

    // Link side: reset while frame select is high, so a rising select ends
    // the frame even though the serial clock stops there.
    logic linkRstN;
    assign linkRstN = nrst && !frameSelectN;

    sfd_phase_t phase;
    logic [2:0] bitIdx;
    logic [SFD_DATA_W-2:0] shiftIn;
    logic [SFD_ADDR_W-1:0] addr;
    logic [4:0] block;
    logic dir;
    logic [1:0] mode;
    logic [2:0] bytesLeft;
    sfd_access_t reqWord;
    logic reqTog;
    logic [SFD_DATA_W-1:0] byteIn;

    assign byteIn = {shiftIn, mosi};

    // Bit counter wraps once per byte; a high select clears it
    always_ff @(posedge sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            bitIdx <= SFD_BIT_RST;
            shiftIn <= '0;
        end else begin
            bitIdx <= bitIdx + 3'h1;
            shiftIn <= byteIn[SFD_DATA_W-2:0];
        end
    end

    // Phase moves on only at the last bit of each byte
    always_ff @(posedge sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            phase <= SFD_PH_ADDR_HI;
            addr <= SFD_ADDR_RST;
            block <= '0;
            dir <= SFD_DIR_READ;
            mode <= SFD_MODE_VAR;
            bytesLeft <= '0;
        end else if (bitIdx == SFD_LAST_BIT) begin
            unique case (phase)
                SFD_PH_ADDR_HI: begin
                    addr[15:8] <= byteIn;
                    phase <= SFD_PH_ADDR_LO;
                end
                SFD_PH_ADDR_LO: begin
                    addr[7:0] <= byteIn;
                    phase <= SFD_PH_CTRL;
                end
                SFD_PH_CTRL: begin
                    block <= byteIn[SFD_BLK_MSB:SFD_BLK_LSB];
                    dir <= byteIn[SFD_DIR_BIT];
                    mode <= byteIn[SFD_MODE_MSB:SFD_MODE_LSB];
                    bytesLeft <= fnLen(byteIn[SFD_MODE_MSB:SFD_MODE_LSB]);
                    phase <= SFD_PH_DATA;
                end
                SFD_PH_DATA: begin
                    addr <= addr + 16'h0001;
                    if (mode != SFD_MODE_VAR) begin
                        bytesLeft <= bytesLeft - 3'h1;
                        if (bytesLeft == 3'h1) begin
                            phase <= SFD_PH_ADDR_HI;
                        end
                    end
                    // Variable mode stays in data until select rises
                end
            endcase
        end
    end

    // Each posted access is a word held stable while its toggle crosses
    // Reads are asked at the last bit of the byte before, half a period before that byte is loaded for output
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            reqWord <= '0;
            reqTog <= 1'b0;
        end else if (frameSelectN) begin
            reqTog <= reqTog;
        end else if (bitIdx == SFD_LAST_BIT) begin
            if (phase == SFD_PH_CTRL && byteIn[SFD_DIR_BIT] == SFD_DIR_READ) begin
                reqWord <= fnPack(addr, byteIn[SFD_BLK_MSB:SFD_BLK_LSB],
                    SFD_DIR_READ, SFD_DATA_RST);
                reqTog <= !reqTog;
            end else if (phase == SFD_PH_DATA) begin
                if (dir == SFD_DIR_WRITE) begin
                    reqWord <= fnPack(addr, block, dir, byteIn);
                    reqTog <= !reqTog;
                end else if (mode == SFD_MODE_VAR || bytesLeft != 3'h1) begin
                    reqWord <= fnPack(addr + 16'h0001, block, dir, SFD_DATA_RST);
                    reqTog <= !reqTog;
                end
            end
        end
    end

    // Read data: system side captures a byte and toggles; link side syncs
    logic [SFD_DATA_W-1:0] rdHold;
    logic rdTog;
    logic rdSync1;
    logic rdSync2;
    logic rdSeen;
    logic [SFD_DATA_W-1:0] rdShadow;

    // Limitation: a new byte must wait until the previous one has crossed
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdHold <= SFD_DATA_RST;
            rdTog <= 1'b0;
        end else if (rdValid) begin
            rdHold <= rdData;
            rdTog <= !rdTog;
        end
    end

    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            rdSync1 <= 1'b0;
            rdSync2 <= 1'b0;
            rdSeen <= 1'b0;
            rdShadow <= SFD_DATA_RST;
        end else begin
            rdSync1 <= rdTog;
            rdSync2 <= rdSync1;
            rdSeen <= rdSync2;
            if (rdSync2 != rdSeen) begin
                rdShadow <= rdHold;
            end
        end
    end

    // Output changes on the falling edge, one half period before the host
    // samples it on the rising edge.
    logic [SFD_DATA_W-1:0] misoShift;

    // Enable follows the phase, so it drops as soon as a fixed frame ends
    always_ff @(negedge sclk or negedge linkRstN) begin
        if (!linkRstN) begin
            misoShift <= SFD_DATA_RST;
            misoOut <= 1'b0;
            misoOe <= 1'b0;
        end else begin
            misoOe <= (phase == SFD_PH_DATA) && (dir == SFD_DIR_READ);
            if (bitIdx == SFD_BIT_RST) begin
                misoShift <= {rdShadow[SFD_DATA_W-2:0], 1'b0};
                misoOut <= rdShadow[SFD_DATA_W-1];
            end else begin
                misoShift <= {misoShift[SFD_DATA_W-2:0], 1'b0};
                misoOut <= misoShift[SFD_DATA_W-1];
            end
        end
    end

    // System side: toggle crossing into the FIFO
    logic reqSync1;
    logic reqSync2;
    logic reqSeen;
    logic pushValid;
    logic pushReady;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reqSync1 <= 1'b0;
            reqSync2 <= 1'b0;
            reqSeen <= 1'b0;
        end else begin
            reqSync1 <= reqTog;
            reqSync2 <= reqSync1;
            reqSeen <= reqSync2;
        end
    end

    // Each new toggle level stands for exactly one posted word
    assign pushValid = reqSync2 != reqSeen;

    // The host cannot be stalled, so a full FIFO drops the word and says so
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            overflow <= 1'b0;
        end else if (pushValid && !pushReady) begin
            overflow <= 1'b1;
        end else if (clrOverflow) begin
            overflow <= 1'b0;
        end
    end

    // Queue absorbs bursts while the consumer holds ready low
    sfd_fifo #(
        .WIDTH(SFD_ACC_W),
        .DEPTH(SFD_FIFO_DEPTH)
    ) accFifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(reqWord),
        .outValid(accValid),
        .outReady(accReady),
        .outData(accWord)
    );

endmodule

// ==== test/sfd_frame_decode_checker.sv ====
/* Assertions on the frame decoder ports.
   Assumes sclk idles low outside frames. */
`timescale 1ns/1ps
module sfd_frame_decode_checker
    import sfd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic frameSelectN,
    input wire logic mosi,
    input wire logic misoOe,
    input wire logic accValid,
    input wire sfd_access_t accWord
);
    logic [5:0] cnt;
    logic [7:0] ctl;
    logic [5:0] endCnt;
    logic lrst;
    logic fix;
    logic last;
    assign lrst = !nrst || frameSelectN;
    assign fix = ctl[1:0] != 2'h0;
    assign endCnt = ctl[1] ? (ctl[0] ? 6'h37 : 6'h27) : 6'h1F;
    assign last = fix && cnt >= 6'h18 && cnt == endCnt;
    // Fixed frames wrap the count; long variable frames saturate it
    always_ff @(posedge sclk or posedge lrst) begin
        if (lrst) begin
            cnt <= 6'h00;
            ctl <= 8'h00;
        end else begin
            if (cnt >= 6'h10 && cnt < 6'h18)
                ctl <= {ctl[6:0], mosi};
            if (last)
                cnt <= 6'h00;
            else if (cnt != 6'h3F)
                cnt <= cnt + 6'h01;
        end
    end
    AST_HDR_QUIET: assert property (
        @(posedge sclk) disable iff (lrst) cnt < 6'h18 |-> !misoOe)
        else $error("miso driven in header");
    AST_READ_DRIVE: assert property (
        @(posedge sclk) disable iff (lrst)
        cnt >= 6'h18 && !ctl[2] |-> misoOe) else $error("read not driven");
    AST_WRITE_QUIET: assert property (
        @(posedge sclk) disable iff (lrst)
        cnt >= 6'h18 && ctl[2] |-> !misoOe) else $error("write drives miso");
    AST_FIX_END: assert property (
        @(posedge sclk) disable iff (lrst) last |=> !misoOe)
        else $error("fixed frame overran");
    AST_VAR_LONG: assert property (
        @(posedge sclk) disable iff (lrst)
        cnt == 6'h20 && !fix && !ctl[2] |-> misoOe [*2])
        else $error("variable read cut short");
    AST_SEL_END: assert property (
        @(posedge clk_sys) disable iff (!nrst) frameSelectN |-> !misoOe)
        else $error("miso driven after select");
    AST_S7_RX: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        accValid && accWord.block == SFD_BLK_S7_RX |->
        accWord.socket == 3'h7 && accWord.area == SFD_AREA_RX)
        else $error("block 1F misrouted");
    AST_RSV_FLAG: assert property (
        @(posedge clk_sys) disable iff (!nrst) accValid |->
        accWord.reserved == (accWord.block != 5'h00 &&
        accWord.block[1:0] == 2'h0)) else $error("reserved flag wrong");
    cover property (@(posedge sclk) last && !ctl[2]);
    cover property (@(posedge clk_sys)
        accValid && accWord.area == SFD_AREA_RX);
    cover property (@(posedge clk_sys) accValid && !accWord.isWrite);
endmodule

// ==== test/sfd_host_model.sv ====
/* Host model: serial bus master, clock stands still between frames.
   Assumes the decoder samples mosi on sclk rising edges. */
`timescale 1ns/1ps
module sfd_host_model (
    output logic sclk,
    output logic frameSelectN,
    output logic mosi,
    input wire logic misoOut,
    input wire logic misoOe
);
    logic [31:0] rdBits;
    initial begin
        sclk = 1'b0;
        frameSelectN = 1'b1;
        mosi = 1'b0;
        rdBits = 32'h0;
    end
    // Data bytes repeat the 32-bit pattern for frames longer than 4 bytes
    task automatic frame(input logic [23:0] hdr, input int nb,
                         input logic [31:0] wd, input bit fixed);
        int i;
        frameSelectN = 1'b0;
        for (i = 0; i < 24 + 8 * nb; i++) begin
            mosi = i < 24 ? hdr[23 - i] : wd[31 - (i - 24) % 32];
            #16 sclk = 1'b1;
            rdBits = {rdBits[30:0], misoOe ? misoOut : 1'bx};
            #16 sclk = 1'b0;
        end
        mosi = ~mosi;
        if (!fixed)
            #16 frameSelectN = 1'b1;
    endtask
endmodule

// ==== test/tb_sfd_frame_decode.sv ====
/* Bench for the frame decoder: host frames in, access words out.
   Assumes the host model paces the link clock at 32 ns. */
`timescale 1ns/1ps
module tb_sfd_frame_decode
    import sfd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic accReady = 1'b1;
    logic rdValid = 1'b0;
    logic clrOverflow = 1'b0;
    logic [7:0] rdData = 8'h00;
    wire sclk, frameSelectN, mosi, misoOut, misoOe, accValid, overflow;
    sfd_access_t accWord;
    sfd_access_t got[$];
    int failures = 0;
    int n_compared = 0;
    int k;
    int j;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (accValid && accReady)
            got.push_back(accWord);
    sfd_frame_decode dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk),
        .frameSelectN(frameSelectN), .mosi(mosi), .misoOut(misoOut),
        .misoOe(misoOe), .accValid(accValid), .accReady(accReady),
        .accWord(accWord), .rdValid(rdValid), .rdData(rdData),
        .overflow(overflow), .clrOverflow(clrOverflow));
    sfd_host_model host (.sclk(sclk), .frameSelectN(frameSelectN),
        .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe));
    task automatic end_of_test();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic sfd_access_t word(input logic [15:0] a,
        input logic [4:0] b, input logic w, input logic [7:0] d);
        word = '{a, b, b[4:2], b == 5'h00 ? 2'h0 : b[1:0],
                 b != 5'h00 && b[1:0] == 2'h0, w, d};
    endfunction
    task automatic wait_words(input int n);
        int t;
        @(negedge clk_sys);
        for (t = 0; t < 400 && got.size() < n; t++)
            @(negedge clk_sys);
        chk(got.size(), n);
        if (got.size() < n)
            end_of_test();
    endtask
    task automatic pulse(input logic [7:0] d);
        @(negedge clk_sys);
        rdData = d;
        rdValid = 1'b1;
        @(negedge clk_sys);
        rdValid = 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [4:0] b,
                      input logic [1:0] m, input int nb, input logic [31:0] d);
        got.delete();
        host.frame({a, b, 1'b1, m}, nb, d, m != 2'h0);
        wait_words(nb);
        for (k = 0; k < nb; k++)
            chk(got[k], word(a + 16'(k), b, 1'b1,
                d[31 - 8 * (k % 4) -: 8]));
    endtask
    // Read bytes are prefetched: each must cross before its byte starts
    task automatic rd(input logic [15:0] a, input logic [4:0] b,
                      input logic [1:0] m, input logic [15:0] d);
        int n;
        n = m == 2'h0 ? 3 : 2;
        got.delete();
        pulse(d[15:8]);
        fork
            host.frame({a, b, 1'b0, m}, 2, 32'h0, m != 2'h0);
            begin
                #880;
                pulse(d[7:0]);
            end
        join
        wait_words(n);
        for (k = 0; k < n; k++)
            chk(got[k], word(a + 16'(k), b, 1'b0, 8'h00));
        chk(host.rdBits[15:0], d);
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (3) @(negedge clk_sys);
        wr(16'h0018, 5'h00, 2'h0, 1, 32'hAA000000);
        wr(16'h0040, 5'h06, 2'h0, 5, 32'h11223344);
        wr(16'h0007, 5'h19, 2'h0, 1, 32'h3C000000);
        rd(16'h0100, 5'h0F, 2'h0, 16'hBBCC);
        // Host cannot be stalled, so the word past 17 is dropped
        accReady = 1'b0;
        got.delete();
        host.frame({16'h0300, 5'h0A, 1'b1, 2'h0}, 18, 32'h5A5A5A5A, 1'b0);
        repeat (10) @(negedge clk_sys);
        chk(overflow, 1'b1);
        accReady = 1'b1;
        wait_words(17);
        chk(got[16], word(16'h0310, 5'h0A, 1'b1, 8'h5A));
        clrOverflow = 1'b1;
        @(negedge clk_sys);
        clrOverflow = 1'b0;
        @(negedge clk_sys);
        chk(overflow, 1'b0);
        // Select stays low from here on
        rd(16'h0280, 5'h1D, 2'h2, 16'h6E91);
        // A frame follows the fixed read, so its end is seen by the checker
        for (j = 1; j < 4; j++)
            wr(16'h0200, 5'h1F, j[1:0], 1 << (j - 1),
                32'hC3A51E69);
        end_of_test();
    end
endmodule
bind sfd_frame_decode sfd_frame_decode_checker chk_i (.clk_sys(clk_sys),
    .nrst(nrst), .sclk(sclk), .frameSelectN(frameSelectN), .mosi(mosi),
    .misoOe(misoOe), .accValid(accValid), .accWord(accWord));
